// File: hw/pds_stage.v
// pwm output stage: dead-band, shutdown restart and pulse steering
`timescale 1ns/1ns
`include "pds_defines.vh"
module pds_stage (
  input wire clk_i,
  input wire rst_n_i,
  input wire [`PDS_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  input wire pwm_raw_i,
  input wire period_start_i,
  input wire [3:0] unit_mode_select_i,
  input wire [1:0] output_config_select_i,
  input wire [1:0] shut_state_ac_i,
  input wire [1:0] shut_state_bd_i,
  input wire shutdown_cond_i,
  input wire [3:0] pin_direction_bit_i,
  input wire [3:0] port_data_i,
  input wire sleep_i,
  input wire primary_idle_mode_i,
  input wire managed_mode_i,
  input wire fail_monitor_en_i,
  input wire clk_fail_i,
  output wire [3:0] pin_o,
  output wire [3:0] pin_oe_o,
  output wire [1:0] period_clk_sel_o,
  output wire internal_osc_run_mode_o,
  output wire osc_fail_flag_o,
  output wire shutdown_event_status_o
);

  //==================================================
  // shutdown state decode
  // returns {drive, level} for a shutdown state field
  function [1:0] pds_shut_decode;
    input [1:0] field;
    begin
      pds_shut_decode = {~field[1], field[0] & ~field[1]};
    end
  endfunction

  // strobe qualified by one register index
  function pds_hit;
    input strobe;
    input [`PDS_ADDR_W-1:0] addr;
    input [`PDS_ADDR_W-1:0] index;
    begin
      pds_hit = strobe && (addr == index);
    end
  endfunction

  //==================================================
  // synchronisers for pin inputs
  reg [1:0] shut_sync_reg;
  reg [1:0] fail_sync_reg;
  wire shut_cond;
  wire clk_fail;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shut_sync_reg <= 2'h0;
      fail_sync_reg <= 2'h0;
    end else begin
      shut_sync_reg <= {shut_sync_reg[0], shutdown_cond_i};
      fail_sync_reg <= {fail_sync_reg[0], clk_fail_i};
    end
  end

  assign shut_cond = shut_sync_reg[1];
  assign clk_fail = fail_sync_reg[1];

  //==================================================
  // freeze in sleep
  wire hold;
  assign hold = sleep_i;

  //==================================================
  // registers
  reg [7:0] delay_reg;
  reg [4:0] steer_reg;
  reg [3:0] steer_eff_reg;
  reg [3:0] steer_eff_next;
  reg ase_reg;
  reg ase_next;
  reg run_reg;
  reg run_next;
  reg oscf_reg;
  reg oscf_next;
  reg irun_reg;
  reg irun_next;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;

  wire wr_delay;
  wire wr_steer;
  wire wr_stat;
  wire [6:0] dead_count;
  wire auto_restart;
  wire steer_sync;

  assign wr_delay = pds_hit(wr_i, addr_i, `PDS_ADDR_DELAY);
  assign wr_steer = pds_hit(wr_i, addr_i, `PDS_ADDR_STEER);
  assign wr_stat = pds_hit(wr_i, addr_i, `PDS_ADDR_STAT);
  assign dead_count = delay_reg[6:0];
  assign auto_restart = delay_reg[`PDS_RESTART_BIT];
  assign steer_sync = steer_reg[`PDS_SYNC_BIT];

  //==================================================
  // mode decode
  wire pwm_mode;
  wire steer_mode;
  wire half_mode;
  wire pol_ac;
  wire pol_bd;

  assign pwm_mode = (unit_mode_select_i[3:2] == `PDS_MODE_PWM);
  assign steer_mode = pwm_mode &&
    (output_config_select_i == `PDS_CFG_SINGLE);
  assign half_mode = pwm_mode &&
    (output_config_select_i == `PDS_CFG_HALF);
  // one means active low
  assign pol_ac = unit_mode_select_i[1];
  assign pol_bd = unit_mode_select_i[0];

  //==================================================
  // shutdown status and restart
  always @* begin
    ase_next = ase_reg;
    run_next = run_reg;
    if (wr_stat && !shut_cond) begin
      // writes are ignored while the condition persists
      ase_next = wdata_i[`PDS_STAT_ASE_BIT];
    end
    if (ase_reg && !shut_cond && auto_restart) begin
      ase_next = 1'b0;
    end
    if (shut_cond) begin
      ase_next = 1'b1;
    end
    if (ase_reg || ase_next) begin
      run_next = 1'b0;
    end else if (period_start_i) begin
      run_next = 1'b1;
    end
  end

  //==================================================
  // steering update
  always @* begin
    steer_eff_next = steer_eff_reg;
    if (!steer_sync) begin
      steer_eff_next = steer_reg[3:0];
    end else if (period_start_i) begin
      steer_eff_next = steer_reg[3:0];
    end
  end

  //==================================================
  // clock source selection and fail-safe
  always @* begin
    oscf_next = oscf_reg;
    irun_next = irun_reg;
    if (wr_stat && !wdata_i[`PDS_STAT_OSCF_BIT]) begin
      oscf_next = 1'b0;
    end
    if (fail_monitor_en_i && clk_fail) begin
      oscf_next = 1'b1;
      irun_next = 1'b1;
    end else if (!clk_fail) begin
      irun_next = 1'b0;
    end
  end

  reg [1:0] clk_sel_reg;
  reg [1:0] clk_sel_next;

  always @* begin
    if (irun_reg) begin
      clk_sel_next = `PDS_CLK_INTERNAL;
    end else if (managed_mode_i && !primary_idle_mode_i) begin
      clk_sel_next = `PDS_CLK_MANAGED;
    end else begin
      clk_sel_next = `PDS_CLK_PRIMARY;
    end
  end

  //==================================================
  // read mux
  always @* begin
    rdata_next = 8'h00;
    case (addr_i)
      `PDS_ADDR_DELAY: begin
        rdata_next = delay_reg;
      end
      `PDS_ADDR_STEER: begin
        rdata_next = {3'h0, steer_reg};
      end
      `PDS_ADDR_STAT: begin
        rdata_next[`PDS_STAT_ASE_BIT] = ase_reg;
        rdata_next[`PDS_STAT_OSCF_BIT] = oscf_reg;
        rdata_next[`PDS_STAT_IRUN_BIT] = irun_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  //==================================================
  // state flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      delay_reg <= `PDS_DELAY_RST;
      steer_reg <= `PDS_STEER_RST;
      steer_eff_reg <= 4'h0;
      ase_reg <= 1'b0;
      run_reg <= 1'b0;
      oscf_reg <= 1'b0;
      irun_reg <= 1'b0;
      clk_sel_reg <= `PDS_CLK_PRIMARY;
      rdata_reg <= 8'h00;
    end else begin
      // fail-safe and clock choice keep working in sleep
      oscf_reg <= oscf_next;
      irun_reg <= irun_next;
      clk_sel_reg <= clk_sel_next;
      if (rd_i) begin
        rdata_reg <= rdata_next;
      end
      if (wr_delay) begin
        delay_reg <= wdata_i;
      end
      if (wr_steer) begin
        steer_reg <= wdata_i[4:0];
      end
      if (!hold) begin
        steer_eff_reg <= steer_eff_next;
        ase_reg <= ase_next;
        run_reg <= run_next;
      end
    end
  end

  //==================================================
  // dead-band paths
  wire req_a;
  wire req_b;
  wire mod_a;
  wire mod_b;
  wire [6:0] eff_count;

  assign req_a = run_reg && pwm_raw_i;
  assign req_b = run_reg && !pwm_raw_i && half_mode;
  // single-output mode passes with no dead time
  assign eff_count = half_mode ? dead_count : 7'h00;

  pds_deadband u_dead_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .hold_i(hold),
    .req_i(req_a),
    .count_i(eff_count),
    .out_o(mod_a)
  );

  pds_deadband u_dead_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .hold_i(hold),
    .req_i(req_b),
    .count_i(eff_count),
    .out_o(mod_b)
  );

  //==================================================
  // pin drivers
  wire [3:0] pwm_on;
  wire [3:0] mod_pin;
  wire [3:0] pol_pin;
  wire [1:0] shut_ac;
  wire [1:0] shut_bd;

  assign shut_ac = pds_shut_decode(shut_state_ac_i);
  assign shut_bd = pds_shut_decode(shut_state_bd_i);
  assign pol_pin = {pol_bd, pol_ac, pol_bd, pol_ac};
  // half-bridge: second pin is the complement; steering: one waveform
  assign mod_pin = half_mode ? {mod_a, mod_a, mod_b, mod_a} :
    {mod_a, mod_a, mod_a, mod_a};
  assign pwm_on = steer_mode ? steer_eff_reg :
    (half_mode ? 4'h3 : 4'h0);

  reg [3:0] pin_reg;
  reg [3:0] pin_oe_reg;
  wire [3:0] pin_next_all;
  wire [3:0] oe_next_all;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      wire [1:0] shut_sel;
      reg pin_next;
      reg oe_next;
      assign shut_sel = (gi == 0 || gi == 2) ? shut_ac : shut_bd;
      assign pin_next_all[gi] = pin_next;
      assign oe_next_all[gi] = oe_next;
      always @* begin
        pin_next = port_data_i[gi];
        oe_next = !pin_direction_bit_i[gi];
        if (pwm_on[gi]) begin
          if (ase_reg) begin
            pin_next = shut_sel[0];
            oe_next = !pin_direction_bit_i[gi] && shut_sel[1];
          end else begin
            pin_next = mod_pin[gi] ^ pol_pin[gi];
          end
        end
      end
    end
  endgenerate

  // one process owns all pin flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 4'h0;
      pin_oe_reg <= 4'h0;
    end else if (!hold) begin
      pin_reg <= pin_next_all;
      pin_oe_reg <= oe_next_all;
    end
  end

  //==================================================
  // outputs
  assign pin_o = pin_reg;
  assign pin_oe_o = pin_oe_reg;
  assign rdata_o = rdata_reg;
  assign period_clk_sel_o = clk_sel_reg;
  assign internal_osc_run_mode_o = irun_reg;
  assign osc_fail_flag_o = oscf_reg;
  assign shutdown_event_status_o = ase_reg;

endmodule // pds_stage

// File: include/pds_defines.vh
// constants for the pwm dead-band and steering stage
//==================================================
// Contract
// - half-bridge delays only inactive-to-active output edges by dead-band time
// - dead-band length is seven-bit count in low bits of delay register
// - each count unit adds one instruction cycle before output goes active
// - auto-restart set: shutdown status clears by itself when condition ends
// - steering works only with mode upper bits 11 and output config 00
// - steering enable bits 0..3 route pwm to pins a..d, else port control
// - all steered pins carry the same modulated waveform at once
// - low two mode bits set polarity of all steered outputs
// - shutdown forces only steered pins into shutdown state; in half-bridge mode pins a and b are forced too
// - sync bit 0: new steering applies right after the register write
// - sync bit 1: new steering applies at next pwm period start
// - pwm reaches a pin only when its direction bit is 0
// - steering register bits 7..5 always read zero
// - sleep freezes pin, steering, shutdown and dead-band state; pins hold and resume afterwards
// - primary idle keeps primary clock; other managed modes use their clock
// - clock failure with monitor on selects internal osc and sets fail flag
// - after shutdown ends, modulation resumes at next period start
`ifndef PDS_DEFINES_VH
`define PDS_DEFINES_VH
//==================================================
// register map
`define PDS_ADDR_W 2
`define PDS_ADDR_DELAY 2'h0
`define PDS_ADDR_STEER 2'h1
`define PDS_ADDR_STAT 2'h2
`define PDS_DELAY_RST 8'h00
`define PDS_STEER_RST 5'h01
//==================================================
// field positions
`define PDS_RESTART_BIT 7
`define PDS_SYNC_BIT 4
`define PDS_STAT_ASE_BIT 7
`define PDS_STAT_OSCF_BIT 0
`define PDS_STAT_IRUN_BIT 1
//==================================================
// mode encodings
`define PDS_MODE_PWM 2'h3
`define PDS_CFG_SINGLE 2'h0
`define PDS_CFG_HALF 2'h2
`define PDS_CLK_PRIMARY 2'h0
`define PDS_CLK_MANAGED 2'h1
`define PDS_CLK_INTERNAL 2'h2
`endif

// File: hw/pds_deadband.v
// dead-band delay on the inactive-to-active edge of one output
`timescale 1ns/1ns
module pds_deadband (
  input wire clk_i,
  input wire rst_n_i,
  input wire hold_i,
  input wire req_i,
  input wire [6:0] count_i,
  output wire out_o
);
  reg [6:0] cnt_reg;
  reg [6:0] cnt_next;
  reg out_reg;
  reg out_next;
  reg req_reg;

  always @* begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!req_i) begin
      out_next = 1'b0;
      cnt_next = 7'h00;
    end else if (!req_reg) begin
      cnt_next = count_i;
      out_next = (count_i == 7'h00);
    end else if (!out_reg) begin
      if (cnt_reg <= 7'h01) begin
        out_next = 1'b1;
      end
      cnt_next = cnt_reg - 7'h01;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 7'h00;
      out_reg <= 1'b0;
      req_reg <= 1'b0;
    end else if (!hold_i) begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      req_reg <= req_i;
    end
  end

  assign out_o = out_reg;
endmodule // pds_deadband

// File: sim/pds_stage_asserts.sv
// port checker for the pwm output stage
`timescale 1ns/1ns
module pds_stage_asserts (
  input wire clk_i,
  input wire rst_n_i,
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [3:0] pin_direction_bit_i,
  input wire sleep_i,
  input wire shutdown_cond_i,
  input wire primary_idle_mode_i,
  input wire managed_mode_i,
  input wire fail_monitor_en_i,
  input wire clk_fail_i,
  input wire [3:0] pin_o,
  input wire [3:0] pin_oe_o,
  input wire [1:0] period_clk_sel_o,
  input wire internal_osc_run_mode_o,
  input wire osc_fail_flag_o,
  input wire shutdown_event_status_o
);
  // ====
  // restart enable mirror
  reg restart_reg;
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) restart_reg <= 1'b0;
    else if (wr_i && addr_i == 2'h0) restart_reg <= wdata_i[7];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // checks
  steer_msb_zero_a: assert property (rd_i && addr_i == 2'h1 |=> rdata_o[7:5] == 3'h0)
    else $error("steer msb set");
  dir_input_a: assert property (
    !$past(sleep_i) |-> (pin_oe_o & $past(pin_direction_bit_i)) == 4'h0)
    else $error("input pin driven");
  sleep_hold_a: assert property (sleep_i |=> $stable(pin_o) && $stable(pin_oe_o))
    else $error("pins moved in sleep");
  shut_set_a: assert property (shutdown_cond_i [*4] |=> shutdown_event_status_o)
    else $error("status not set");
  fw_clear_a: assert property (
    !restart_reg && shutdown_event_status_o && !(wr_i && addr_i == 2'h2)
    |=> shutdown_event_status_o)
    else $error("status cleared alone");
  fail_sel_a: assert property (
    (fail_monitor_en_i && clk_fail_i) [*4] |=>
    osc_fail_flag_o && internal_osc_run_mode_o && period_clk_sel_o == 2'h2)
    else $error("fail not handled");
  idle_clk_a: assert property (
    primary_idle_mode_i && !internal_osc_run_mode_o
    |=> period_clk_sel_o == 2'h0)
    else $error("idle clock wrong");
  managed_clk_a: assert property (
    managed_mode_i && !primary_idle_mode_i && !internal_osc_run_mode_o
    |=> period_clk_sel_o == 2'h1)
    else $error("managed clock wrong");
  cover property (shutdown_event_status_o ##1 !shutdown_event_status_o);
  cover property (sleep_i ##1 sleep_i);
  cover property (osc_fail_flag_o);
endmodule // pds_stage_asserts
bind pds_stage pds_stage_asserts pds_stage_asserts_i (.*);

// File: sim/pds_gate_model.sv
// bridge gate driver model: counts shoot-through on the half-bridge leg
`timescale 1ns/1ns
module pds_gate_model (
  input wire clk_i,
  input wire half_i,
  input wire [3:0] pin_i,
  input wire [3:0] pin_oe_i,
  output reg [15:0] overlap_o
);
  initial overlap_o = 16'h0000;
  // both switches of one leg on together
  always @(posedge clk_i)
    if (half_i && &pin_i[1:0] && &pin_oe_i[1:0]) overlap_o <= overlap_o + 16'h0001;
endmodule // pds_gate_model

// File: sim/tb_top.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  // ====
  // signals
  reg clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  reg pwm_raw_i = 1'b0, period_start_i = 1'b0, shutdown_cond_i = 1'b0, sleep_i = 1'b0;
  reg primary_idle_mode_i = 1'b0, managed_mode_i = 1'b0;
  reg fail_monitor_en_i = 1'b0, clk_fail_i = 1'b0;
  reg [1:0] addr_i = 2'h0, output_config_select_i = 2'h0;
  reg [1:0] shut_state_ac_i = 2'h0, shut_state_bd_i = 2'h0;
  reg [7:0] wdata_i = 8'h00;
  reg [3:0] unit_mode_select_i = 4'hc, pin_direction_bit_i = 4'h0, port_data_i = 4'h0, s, e4;
  wire [7:0] rdata_o;
  wire [3:0] pin_o, pin_oe_o;
  wire [1:0] period_clk_sel_o;
  wire internal_osc_run_mode_o, osc_fail_flag_o, shutdown_event_status_o;
  wire [15:0] overlap;
  integer n_fail = 0, tests_run = 0, cyc = 0, i, n, d;
  pds_stage pds_stage_i (.*);
  pds_gate_model pds_gate_model_i (.clk_i(clk_i), .half_i(output_config_select_i == 2'h2),
    .pin_i(pin_o), .pin_oe_i(pin_oe_o), .overlap_o(overlap));
  always #5 clk_i = ~clk_i;
  // ====
  // helpers
  function [3:0] exp_pin(input [3:0] st, input [3:0] m, input [1:0] c, input p,
    input [3:0] pd);
    integer k;
    for (k = 0; k < 4; k++)
      exp_pin[k] = (m[3:2] == 2'h3 && c == 2'h0 && st[k]) ? p ^ m[1 - k % 2] : pd[k];
  endfunction
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk_i);
      #1;
    end
  endtask
  task wreg(input [1:0] a, input [7:0] v);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rreg(input [1:0] a, input [7:0] e);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      tick(1);
      rd_i <= 1'b0;
      `CHK("rdata", e, rdata_o)
    end
  endtask
  task period;
    begin
      @(posedge clk_i);
      period_start_i <= 1'b1;
      @(posedge clk_i);
      period_start_i <= 1'b0;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  // ====
  // sequence
  initial begin
    void'($urandom(32'hcf8c));
    tick(3);
    rst_n_i <= 1'b1;
    rreg(2'h0, 8'h00);
    rreg(2'h1, 8'h01);
    wreg(2'h3, 8'hff);
    rreg(2'h3, 8'h00);
    wreg(2'h1, 8'hff);
    rreg(2'h1, 8'h1f);
    $display("regs done");
    period;
    for (i = 0; i < 24; i++) begin
      s = 4'($urandom);
      unit_mode_select_i <= {(i > 21) ? 2'h2 : 2'h3, 2'($urandom)};
      output_config_select_i <= (i == 20) ? 2'h1 : (i == 21) ? 2'h3 : 2'h0;
      pin_direction_bit_i <= (i % 3 == 0) ? 4'($urandom) : 4'h0;
      port_data_i <= 4'($urandom);
      pwm_raw_i <= 1'($urandom);
      wreg(2'h1, {4'h0, s});
      tick(4);
      e4 = exp_pin(s, unit_mode_select_i, output_config_select_i, pwm_raw_i, port_data_i);
      `CHK("pin", e4 & ~pin_direction_bit_i, pin_o & ~pin_direction_bit_i)
      `CHK("oe", ~pin_direction_bit_i, pin_oe_o)
    end
    $display("steering done");
    unit_mode_select_i <= 4'hc;
    output_config_select_i <= 2'h0;
    pin_direction_bit_i <= 4'h0;
    port_data_i <= 4'h0;
    pwm_raw_i <= 1'b1;
    period;
    wreg(2'h1, 8'h01);
    wreg(2'h1, 8'h12);
    tick(4);
    `CHK("sync_hold", 4'h1, pin_o)
    period;
    tick(3);
    `CHK("sync_new", 4'h2, pin_o)
    $display("sync done");
    output_config_select_i <= 2'h2;
    pwm_raw_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 0 : (i == 1) ? 127 : $urandom % 16;
      wreg(2'h0, 8'(d));
      tick(140);
      pwm_raw_i <= 1'b1;
      n = 0;
      while (pin_o[0] !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      `CHK("rise", d + 2, n)
      pwm_raw_i <= 1'b0;
      tick(2);
      `CHK("fall", {d == 0, 1'b0}, pin_o[1:0])
      n = 2;
      while (pin_o[1] !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      `CHK("comp_rise", d + 2, n)
    end
    $display("deadband done");
    output_config_select_i <= 2'h0;
    shut_state_ac_i <= 2'h1;
    port_data_i <= 4'ha;
    wreg(2'h0, 8'h00);
    wreg(2'h1, 8'h05);
    period;
    shutdown_cond_i <= 1'b1;
    tick(6);
    `CHK("pin_shut", 4'hf, pin_o)
    shutdown_cond_i <= 1'b0;
    tick(6);
    `CHK("ase_kept", 1'b1, shutdown_event_status_o)
    wreg(2'h2, 8'h00);
    tick(2);
    `CHK("ase_fw", 1'b0, shutdown_event_status_o)
    wreg(2'h0, 8'h80);
    shut_state_ac_i <= 2'h2;
    pwm_raw_i <= 1'b1;
    shutdown_cond_i <= 1'b1;
    tick(6);
    `CHK("oe_shut", 4'ha, pin_oe_o)
    shutdown_cond_i <= 1'b0;
    tick(5);
    `CHK("ase_auto", 1'b0, shutdown_event_status_o)
    `CHK("pin_wait", 4'ha, pin_o)
    period;
    tick(3);
    `CHK("pin_resume", 4'hf, pin_o)
    $display("shutdown done");
    sleep_i <= 1'b1;
    pwm_raw_i <= 1'b0;
    tick(4);
    `CHK("pin_sleep", 4'hf, pin_o)
    sleep_i <= 1'b0;
    tick(4);
    `CHK("pin_wake", 4'ha, pin_o)
    primary_idle_mode_i <= 1'b1;
    managed_mode_i <= 1'b1;
    tick(3);
    `CHK("sel_idle", 2'h0, period_clk_sel_o)
    primary_idle_mode_i <= 1'b0;
    tick(3);
    `CHK("sel_mgd", 2'h1, period_clk_sel_o)
    fail_monitor_en_i <= 1'b1;
    clk_fail_i <= 1'b1;
    tick(5);
    `CHK("sel_fail", 2'h2, period_clk_sel_o)
    rreg(2'h2, 8'h03);
    clk_fail_i <= 1'b0;
    tick(5);
    `CHK("irun_off", 1'b0, internal_osc_run_mode_o)
    wreg(2'h2, 8'h00);
    tick(2);
    `CHK("flag_clr", 1'b0, osc_fail_flag_o)
    `CHK("overlap", 16'h0000, overlap)
    $display("clock done");
    stop_test;
  end
endmodule // tb_top
